// ---- rtl/intc_event_pkg.sv ----
// constants, types and helpers of the interrupt and event transfer unit
package intc_event_pkg;
  localparam int NODES = 16;
  localparam int CHANS = 8;
  localparam int EXTS = 4;
  localparam int PRIO_W = 4;
  localparam int CNT_W = 8;
  localparam int PTR_W = 24;
  localparam int RESP_TYPICAL_CYC = 8;
  // register map, byte addresses
  localparam logic [3:0] NODE_PAGE = 4'h0;
  localparam logic [3:0] CHAN_PAGE = 4'h1;
  localparam logic [3:0] MISC_PAGE = 4'h2;
  localparam logic [11:0] NODE_BASE = 12'h000;
  localparam logic [11:0] CHAN_BASE = 12'h100;
  localparam logic [1:0] CH_SRC_W = 2'h0;
  localparam logic [1:0] CH_DST_W = 2'h1;
  localparam logic [1:0] CH_CTL_W = 2'h2;
  localparam logic [11:0] VEC_BASE_OFS = 12'h200;
  localparam logic [11:0] EDGE_OFS = 12'h204;
  localparam logic [11:0] STAT_OFS = 12'h208;
  localparam logic [11:0] MASK_OFS = 12'h20C;
  localparam logic [11:0] STATE_OFS = 12'h210;
  // node control fields
  localparam int PRIO_LSB = 0;
  localparam int EN_BIT = 4;
  localparam int REQ_BIT = 5;
  localparam int ROUTE_BIT = 6;
  localparam int CHSEL_LSB = 7;
  // channel control fields
  localparam int CNT_LSB = 0;
  localparam int CONT_BIT = 8;
  localparam int WORD_BIT = 9;
  localparam int INCS_BIT = 10;
  localparam int INCD_BIT = 11;
  // vectors
  localparam logic [7:0] TRAP_BASE = 8'h10;
  localparam logic [PTR_W-1:0] VEC_BASE_RST = 24'h000000;
  localparam logic [7:0] EDGE_RST = 8'h00;
  localparam logic [PTR_W-1:0] STEP_BYTE = 24'h000001;
  localparam logic [PTR_W-1:0] STEP_WORD = 24'h000002;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_STD = 2'b01,
    ST_XFER = 2'b10
  } state_t;

  typedef struct packed {
    logic [2:0] chSel;
    logic route;
    logic req;
    logic en;
    logic [PRIO_W-1:0] prio;
  } nodeCtl_t;

  typedef struct packed {
    logic incDst;
    logic incSrc;
    logic word;
    logic cont;
    logic [CNT_W-1:0] count;
  } chanCtl_t;

  typedef struct packed {
    logic valid;
    logic word;
    logic [PTR_W-1:0] src;
    logic [PTR_W-1:0] dst;
  } xfer_t;

  function automatic logic [31:0] applySel(input logic [31:0] old,
      input logic [31:0] wd, input logic [3:0] sel);
    logic [31:0] m;
    m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
    return (old & ~m) | (wd & m);
  endfunction : applySel
endpackage : intc_event_pkg

// ---- rtl/interrupt_event_unit.sv ----
// interrupt controller with eight channel event transfer controller
//
// Contract
// - each node is routed by software to a vectored interrupt or to the event_transfer_controller.
// - a routed request steals one cycle for a transfer with no vector branch.
// - a transfer moves a byte or word and steps source, destination or both as set per channel.
// - each channel counter drops by one per transfer, except in continuous mode.
// - a channel counter at zero turns the next request into a standard interrupt; in continuous mode the code still transfers at count zero.
// - the event_transfer_controller has eight channels, each with pointers, counter and mode.
// - each node has a control register with node_request_flag, enable and priority.
// - the priority field picks one of sixteen levels for arbitration.
// - only a request of strictly higher priority than the running service is taken; the code takes a pending trap request at any priority.
// - each node has its own vector location for standard service.
// - fast external inputs detect rising, falling or both edges as programmed.
// - a trap request with a number enters the service routine of that number.
// - software setting a node_request_flag raises a request on that node.
// - the response to a request aims at about eight clock cycles.
//
// Decided for this implementation: the Wishbone interface to the registers and the address map.
module interrupt_event_unit
  import intc_event_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [11:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire logic [NODES-1:0] periphReq,
  input wire logic [EXTS-1:0] extPin,
  input wire logic trapReq,
  input wire logic [7:0] trapNum,
  input wire logic [PRIO_W-1:0] cpuPrio,
  input wire logic cpuAck,
  output logic cpuIrq,
  output logic [PTR_W-1:0] cpuVector,
  output logic [PRIO_W-1:0] cpuIrqPrio,
  output xfer_t xferOut,
  output logic irq
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  state_t state_q;
  nodeCtl_t node_q [NODES];
  chanCtl_t chCtl_q [CHANS];
  logic [PTR_W-1:0] chSrc_q [CHANS];
  logic [PTR_W-1:0] chDst_q [CHANS];
  logic [PTR_W-1:0] vecBase_q;
  logic [7:0] edgeCfg_q;
  logic [CHANS-1:0] stat_q;
  logic [CHANS-1:0] mask_q;
  logic [31:0] datO_q;
  logic [31:0] datO_d;
  logic ack_q;
  logic irq_q;
  logic cpuIrq_q;
  logic [PTR_W-1:0] cpuVector_q;
  logic [PRIO_W-1:0] cpuIrqPrio_q;
  xfer_t xfer_q;
  logic [3:0] curNode_q;
  logic trapSvc_q;
  logic trapPend_q;
  logic [7:0] trapNum_q;
  logic [2:0] xCh_q;
  logic [EXTS-1:0] s1_q;
  logic [EXTS-1:0] s2_q;
  logic [EXTS-1:0] s3_q;
  logic [EXTS-1:0] lvl_q;
  logic [EXTS-1:0] extEv;
  logic [NODES-1:0] hwSet;
  logic [NODES-1:0] clrReq;
  logic [CHANS-1:0] zeroEv;
  logic wbAcc;
  logic wbWr;
  logic [9:0] nodeWr;
  logic bestValid;
  logic [3:0] bestIdx;
  logic [PRIO_W-1:0] bestPrio;
  logic win;
  logic [2:0] selCh;
  logic [CNT_W-1:0] selCnt;
  logic selCont;
  logic goXfer;
  logic issueX;
  logic issueStd;
  logic [7:0] nodeTrap;

  assign dat_o = datO_q;
  assign ack_o = ack_q;
  assign cpuIrq = cpuIrq_q;
  assign cpuVector = cpuVector_q;
  assign cpuIrqPrio = cpuIrqPrio_q;
  assign xferOut = xfer_q;
  assign irq = irq_q;

  // wishbone slave, one wait state, unmapped reads give zero, except channel page reads with address bit 7 set, which alias channels 0 to 7
  assign wbAcc = cyc_i && stb_i && !ack_q;
  assign wbWr = wbAcc && we_i;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      ack_q <= 1'b0;
      datO_q <= 32'h00000000;
    end else begin
      ack_q <= wbAcc;
      datO_q <= datO_d;
    end
  end

  always_comb begin
    datO_d = 32'h00000000;
    nodeWr = 10'(applySel({22'h000000, node_q[adr_i[5:2]]}, dat_i,
                          sel_i));
    case (adr_i[11:8])
      NODE_PAGE: if (adr_i[7:6] == 2'b00) begin
        datO_d = {22'h000000, node_q[adr_i[5:2]]};
      end
      CHAN_PAGE: begin
        case (adr_i[3:2])
          CH_SRC_W: datO_d = {8'h00, chSrc_q[adr_i[6:4]]};
          CH_DST_W: datO_d = {8'h00, chDst_q[adr_i[6:4]]};
          CH_CTL_W: datO_d = {20'h00000, chCtl_q[adr_i[6:4]]};
          default: datO_d = 32'h00000000;
        endcase
      end
      MISC_PAGE: begin
        case (adr_i)
          VEC_BASE_OFS: datO_d = {8'h00, vecBase_q};
          EDGE_OFS: datO_d = {24'h000000, edgeCfg_q};
          STAT_OFS: datO_d = {24'h000000, stat_q};
          MASK_OFS: datO_d = {24'h000000, mask_q};
          STATE_OFS: datO_d = {22'h000000, trapSvc_q, cpuIrq_q,
                               curNode_q, 2'(state_q), 2'b00};
          default: datO_d = 32'h00000000;
        endcase
      end
      default: datO_d = 32'h00000000;
    endcase
  end

  // misc control registers
  always_ff @(posedge core_clk) begin
    if (rst) begin
      vecBase_q <= VEC_BASE_RST;
      edgeCfg_q <= EDGE_RST;
      mask_q <= '0;
    end else if (wbWr) begin
      if (adr_i == VEC_BASE_OFS) begin
        vecBase_q <= 24'(applySel({8'h00, vecBase_q}, dat_i, sel_i));
      end
      if (adr_i == EDGE_OFS && sel_i[0]) begin
        edgeCfg_q <= dat_i[7:0];
      end
      if (adr_i == MASK_OFS && sel_i[0]) begin
        mask_q <= dat_i[7:0];
      end
    end
  end

  // sticky channel-done status, write one to clear, set wins
  always_ff @(posedge core_clk) begin
    if (rst) begin
      stat_q <= '0;
      irq_q <= 1'b0;
    end else begin
      stat_q <= (stat_q & ~((wbWr && adr_i == STAT_OFS && sel_i[0]) ?
                dat_i[7:0] : 8'h00)) | zeroEv;
      irq_q <= |(stat_q & mask_q);
    end
  end

  // fast external inputs: three flops, edge select per pin
  genvar gk;
  for (gk = 0; gk < EXTS; gk++) begin : g_ext
    always_ff @(posedge core_clk) begin
      if (rst) begin
        s1_q[gk] <= 1'b0;
        s2_q[gk] <= 1'b0;
        s3_q[gk] <= 1'b0;
        lvl_q[gk] <= 1'b0;
      end else begin
        s1_q[gk] <= extPin[gk];
        s2_q[gk] <= s1_q[gk];
        s3_q[gk] <= s2_q[gk];
        if (s2_q[gk] == s3_q[gk]) begin
          lvl_q[gk] <= s3_q[gk];
        end
      end
    end
    assign extEv[gk] = (s2_q[gk] == s3_q[gk]) && (s3_q[gk] != lvl_q[gk])
        && (s3_q[gk] ? edgeCfg_q[2*gk] : edgeCfg_q[2*gk+1]);
  end

  assign hwSet = periphReq | {{(NODES-EXTS){1'b0}}, extEv};

  // node control registers
  genvar gi;
  for (gi = 0; gi < NODES; gi++) begin : g_node
    assign clrReq[gi] = 4'(gi) == curNode_q &&
        ((state_q == ST_STD && cpuAck && !trapSvc_q) ||
         state_q == ST_XFER);
    always_ff @(posedge core_clk) begin
      if (rst) begin
        node_q[gi] <= '0;
      end else begin
        if (wbWr && adr_i[11:6] == NODE_BASE[11:6] &&
            adr_i[5:2] == 4'(gi)) begin
          node_q[gi] <= nodeCtl_t'(nodeWr);
        end
        if (clrReq[gi]) begin
          node_q[gi].req <= 1'b0;
        end
        if (hwSet[gi]) begin
          node_q[gi].req <= 1'b1;
        end
      end
    end
  end

  // arbitration over enabled pending nodes
  always_comb begin
    bestValid = 1'b0;
    bestIdx = 4'h0;
    bestPrio = 4'h0;
    for (int i = 0; i < NODES; i++) begin
      if (node_q[i].en && node_q[i].req &&
          (!bestValid || node_q[i].prio > bestPrio)) begin
        bestValid = 1'b1;
        bestIdx = 4'(i);
        bestPrio = node_q[i].prio;
      end
    end
  end

  assign win = bestValid && bestPrio > cpuPrio && !trapPend_q;
  assign selCh = node_q[bestIdx].chSel;
  assign selCnt = chCtl_q[selCh].count;
  assign selCont = chCtl_q[selCh].cont;
  assign goXfer = node_q[bestIdx].route && (selCont || selCnt != 8'h00);
  assign issueX = state_q == ST_IDLE && win && goXfer;
  assign issueStd = state_q == ST_IDLE && win && !goXfer;
  assign nodeTrap = TRAP_BASE + 8'(bestIdx);

  // channel registers
  genvar gc;
  for (gc = 0; gc < CHANS; gc++) begin : g_chan
    logic chHit;
    logic chRun;
    assign chHit = wbWr && adr_i[11:8] == CHAN_PAGE && adr_i[7] == 1'b0
                   && adr_i[6:4] == 3'(gc);
    assign chRun = state_q == ST_XFER && xCh_q == 3'(gc);
    assign zeroEv[gc] = chRun && !chCtl_q[gc].cont &&
                        chCtl_q[gc].count == 8'h01;
    always_ff @(posedge core_clk) begin
      if (rst) begin
        chSrc_q[gc] <= '0;
        chDst_q[gc] <= '0;
        chCtl_q[gc] <= '0;
      end else if (chRun) begin
        if (chCtl_q[gc].incSrc) begin
          chSrc_q[gc] <= chSrc_q[gc] +
              (chCtl_q[gc].word ? STEP_WORD : STEP_BYTE);
        end
        if (chCtl_q[gc].incDst) begin
          chDst_q[gc] <= chDst_q[gc] +
              (chCtl_q[gc].word ? STEP_WORD : STEP_BYTE);
        end
        if (!chCtl_q[gc].cont) begin
          chCtl_q[gc].count <= chCtl_q[gc].count - 8'h01;
        end
      end else if (chHit) begin
        case (adr_i[3:2])
          CH_SRC_W: chSrc_q[gc] <=
              24'(applySel({8'h00, chSrc_q[gc]}, dat_i, sel_i));
          CH_DST_W: chDst_q[gc] <=
              24'(applySel({8'h00, chDst_q[gc]}, dat_i, sel_i));
          CH_CTL_W: chCtl_q[gc] <= chanCtl_t'(12'(applySel(
              {20'h00000, chCtl_q[gc]}, dat_i, sel_i)));
          default: chSrc_q[gc] <= chSrc_q[gc];
        endcase
      end
    end
  end

  // trap requests wait until the controller is idle
  always_ff @(posedge core_clk) begin
    if (rst) begin
      trapPend_q <= 1'b0;
      trapNum_q <= 8'h00;
    end else if (trapReq && !trapPend_q) begin
      trapPend_q <= 1'b1;
      trapNum_q <= trapNum;
    end else if (state_q == ST_STD && trapSvc_q && cpuAck) begin
      trapPend_q <= 1'b0;
    end
  end

  // service sequencer
  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_q <= ST_IDLE;
      cpuIrq_q <= 1'b0;
      cpuVector_q <= '0;
      cpuIrqPrio_q <= '0;
      xfer_q <= '0;
      curNode_q <= 4'h0;
      trapSvc_q <= 1'b0;
      xCh_q <= 3'h0;
    end else begin
      xfer_q.valid <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          if (trapPend_q) begin
            state_q <= ST_STD;
            cpuIrq_q <= 1'b1;
            trapSvc_q <= 1'b1;
            cpuIrqPrio_q <= cpuPrio;
            cpuVector_q <= vecBase_q + {14'h0000, trapNum_q, 2'b00};
          end else if (issueX) begin
            state_q <= ST_XFER;
            curNode_q <= bestIdx;
            xCh_q <= selCh;
            xfer_q.valid <= 1'b1;
            xfer_q.word <= chCtl_q[selCh].word;
            xfer_q.src <= chSrc_q[selCh];
            xfer_q.dst <= chDst_q[selCh];
          end else if (issueStd) begin
            state_q <= ST_STD;
            curNode_q <= bestIdx;
            cpuIrq_q <= 1'b1;
            trapSvc_q <= 1'b0;
            cpuIrqPrio_q <= bestPrio;
            cpuVector_q <= vecBase_q + {14'h0000, nodeTrap, 2'b00};
          end
        end
        ST_STD: begin
          if (cpuAck) begin
            state_q <= ST_IDLE;
            cpuIrq_q <= 1'b0;
            trapSvc_q <= 1'b0;
          end
        end
        ST_XFER: state_q <= ST_IDLE;
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  a_ack_single: assert property (ack_o |=> !ack_o)
    else $error("ack held longer than one cycle");
  a_ack_answer: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("bus request not answered next cycle");
  a_xfer_one_cycle: assert property (
    xferOut.valid |=> !xferOut.valid && !cpuIrq)
    else $error("transfer took more than one cycle");
  a_count_step: assert property (
    issueX && !selCont |=> ##1 chCtl_q[xCh_q].count == $past(selCnt, 2) - 8'h01)
    else $error("transfer counter not decremented");
  a_count_hold: assert property (
    issueX && selCont |=> ##1 chCtl_q[xCh_q].count == $past(selCnt, 2))
    else $error("continuous counter changed");
  a_zero_standard: assert property (
    state_q == ST_IDLE && !trapPend_q && win && node_q[bestIdx].route &&
    !selCont && selCnt == 8'h00 |=> cpuIrq && !xferOut.valid)
    else $error("zero count did not raise standard interrupt");
  a_strict_prio: assert property (
    $rose(cpuIrq) && !trapSvc_q |-> cpuIrqPrio > $past(cpuPrio))
    else $error("interrupt taken without higher priority");
  a_vector_place: assert property (
    $rose(cpuIrq) && !trapSvc_q |->
    cpuVector == $past(vecBase_q) + {14'h0000, TRAP_BASE + 8'(curNode_q), 2'b00})
    else $error("vector location wrong");
  a_response_bound: assert property (
    state_q == ST_IDLE && bestValid && bestPrio > cpuPrio &&
    !node_q[bestIdx].route && cpuPrio == 4'h0 |-> ##[1:8] cpuIrq)
    else $error("response exceeded eight cycles");
  a_irq_level: assert property (irq == $past(|(stat_q & mask_q)))
    else $error("interrupt output does not follow masked status");
endmodule : interrupt_event_unit

// ---- tb/cpu_core_model.sv ----
// cpu core model answering presented interrupts
module cpu_core_model
  import intc_event_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic cpuIrq,
  input wire logic [PRIO_W-1:0] cpuIrqPrio,
  input wire logic [3:0] ackDelay,
  input wire logic ret,
  output logic cpuAck,
  output logic [PRIO_W-1:0] cpuPrio
);
  logic [3:0] waitQ;

  // accept after a chosen number of cycles, one-cycle pulse
  always_ff @(posedge core_clk) begin
    if (rst || cpuAck || !cpuIrq) begin
      cpuAck <= 1'b0;
      waitQ <= 4'h0;
    end else if (waitQ >= ackDelay) begin
      cpuAck <= 1'b1;
    end else begin
      waitQ <= waitQ + 4'h1;
    end
  end

  // service level follows the accepted request until return
  always_ff @(posedge core_clk) begin
    if (rst || ret) begin
      cpuPrio <= 4'h0;
    end else if (cpuIrq && !cpuAck && waitQ >= ackDelay) begin
      cpuPrio <= cpuIrqPrio;
    end
  end
endmodule : cpu_core_model

// ---- tb/test_interrupt_and_event_transfer_unit.sv ----
// self-checking bench of the interrupt and event transfer unit
module test_interrupt_and_event_transfer_unit
  import intc_event_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [23:0] VBASE = 24'h001000;
  logic core_clk, rst, cyc, stb, we, ack, trapReq, cpuIrq, cpuAck;
  logic irq, ret;
  logic [11:0] adr;
  logic [3:0] sel, cpuPrio, cpuIrqPrio, ackDelay, extPin;
  logic [31:0] dat, rdat, q;
  logic [15:0] periphReq;
  logic [7:0] trapNum;
  logic [PTR_W-1:0] cpuVector;
  xfer_t xferOut;
  int err_count, num_checks, n;

  interrupt_event_unit u_dut (.core_clk(core_clk), .rst(rst), .cyc_i(cyc),
    .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(dat),
    .dat_o(rdat), .ack_o(ack), .periphReq(periphReq), .extPin(extPin),
    .trapReq(trapReq), .trapNum(trapNum), .cpuPrio(cpuPrio),
    .cpuAck(cpuAck), .cpuIrq(cpuIrq), .cpuVector(cpuVector),
    .cpuIrqPrio(cpuIrqPrio), .xferOut(xferOut), .irq(irq));
  cpu_core_model u_cpu (.core_clk(core_clk), .rst(rst), .cpuIrq(cpuIrq),
    .cpuIrqPrio(cpuIrqPrio), .ackDelay(ackDelay), .ret(ret),
    .cpuAck(cpuAck), .cpuPrio(cpuPrio));

  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  task automatic close_out();
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : close_out

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
      input string what);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: %s got %h want %h", $time, what, got,
        exp);
    end
  endtask : chk

  task automatic wb(input logic w, input logic [11:0] a,
      input logic [31:0] d);
    int k;
    k = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    do begin
      @(posedge core_clk);
      k++;
    end while (ack !== 1'b1 && k < 16);
    q = rdat;
    chk({31'h0, ack}, 32'h1, "ack");
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge core_clk);
  endtask : wb

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    wb(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    chk(q, e, "read");
  endtask : rd

  function automatic logic [31:0] nc(input logic [3:0] p, input logic e,
      input logic r, input logic rt, input logic [2:0] c);
    return {22'h0, c, rt, r, e, p};
  endfunction : nc

  function automatic logic [11:0] nA(input logic [3:0] i);
    return NODE_BASE + {6'h0, i, 2'b00};
  endfunction : nA

  function automatic logic [11:0] cA(input logic [2:0] c, input logic [1:0] k);
    return CHAN_BASE + {5'h0, c, 4'h0} + {8'h0, k, 2'b00};
  endfunction : cA

  task automatic pulse(input logic [15:0] m);
    periphReq <= m;
    @(posedge core_clk);
    periphReq <= 16'h0;
  endtask : pulse

  task automatic retNow();
    ret <= 1'b1;
    @(posedge core_clk);
    ret <= 1'b0;
  endtask : retNow

  task automatic waitIrq(input logic [7:0] t, input logic [3:0] p,
      input logic doRet);
    n = 0;
    while (cpuIrq !== 1'b1 && n < 40) begin
      @(posedge core_clk);
      n++;
    end
    chk({8'h0, cpuVector}, {8'h0, VBASE + {14'h0, t, 2'b00}}, "vector");
    chk({28'h0, cpuIrqPrio}, {28'h0, p}, "prio");
    while (cpuIrq === 1'b1) @(posedge core_clk);
    if (doRet) retNow();
  endtask : waitIrq

  task automatic waitXfer(input logic [23:0] s, input logic [23:0] d,
      input logic w);
    int k;
    k = 0;
    while (xferOut.valid !== 1'b1 && k < 40) begin
      @(posedge core_clk);
      k++;
    end
    chk({7'h0, xferOut.valid, xferOut.src}, {8'h1, s}, "src");
    chk({7'h0, xferOut.word, xferOut.dst}, {7'h0, w, d}, "dst");
    chk({31'h0, cpuIrq}, 32'h0, "no branch");
  endtask : waitXfer

  task automatic quiet();
    logic seen;
    seen = 1'b0;
    repeat (12) begin
      @(posedge core_clk);
      seen = seen | cpuIrq | xferOut.valid;
    end
    chk({31'h0, seen}, 32'h0, "quiet");
  endtask : quiet

  initial begin
    repeat (20000) @(posedge core_clk);
    err_count++;
    close_out();
  end

  initial begin
    {cyc, stb, we, trapReq, ret} = 5'h0;
    adr = 12'h0;
    sel = 4'hF;
    dat = 32'h0;
    periphReq = 16'h0;
    extPin = 4'h0;
    trapNum = 8'h0;
    ackDelay = 4'h0;
    rst = 1'b1;
    repeat (10) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    rd(STATE_OFS, 32'h0);
    rd(12'h3F0, 32'h0);
    wr(VEC_BASE_OFS, {8'h0, VBASE});
    wr(nA(4'h3), nc(4'h5, 1'b1, 1'b0, 1'b0, 3'h0));
    pulse(16'h0008);
    waitIrq(8'h13, 4'h5, 1'b1);
    chk({31'h0, n <= RESP_TYPICAL_CYC}, 32'h1, "latency");
    rd(nA(4'h3), nc(4'h5, 1'b1, 1'b0, 1'b0, 3'h0));
    wr(nA(4'h8), nc(4'h6, 1'b0, 1'b1, 1'b0, 3'h0));
    quiet();
    ackDelay <= 4'h3;
    wr(nA(4'h9), nc(4'h2, 1'b1, 1'b1, 1'b0, 3'h0));
    waitIrq(8'h19, 4'h2, 1'b1);
    wr(nA(4'h1), nc(4'h3, 1'b1, 1'b0, 1'b0, 3'h0));
    wr(nA(4'h2), nc(4'h7, 1'b1, 1'b0, 1'b0, 3'h0));
    wr(nA(4'h4), nc(4'h7, 1'b1, 1'b0, 1'b0, 3'h0));
    pulse(16'h0006);
    waitIrq(8'h12, 4'h7, 1'b0);
    pulse(16'h0010);
    quiet();
    retNow();
    waitIrq(8'h14, 4'h7, 1'b1);
    waitIrq(8'h11, 4'h3, 1'b1);
    wr(cA(3'h2, CH_SRC_W), 32'h100);
    wr(cA(3'h2, CH_DST_W), 32'h200);
    wr(cA(3'h2, CH_CTL_W), 32'hE02);
    wr(nA(4'h5), nc(4'h4, 1'b1, 1'b0, 1'b1, 3'h2));
    pulse(16'h0020);
    waitXfer(24'h100, 24'h200, 1'b1);
    pulse(16'h0020);
    waitXfer(24'h102, 24'h202, 1'b1);
    rd(cA(3'h2, CH_CTL_W), 32'hE00);
    rd(STAT_OFS, 32'h4);
    chk({31'h0, irq}, 32'h0, "masked");
    wr(MASK_OFS, 32'h4);
    rd(MASK_OFS, 32'h4);
    chk({31'h0, irq}, 32'h1, "irq");
    wr(STAT_OFS, 32'h4);
    rd(STAT_OFS, 32'h0);
    chk({31'h0, irq}, 32'h0, "cleared");
    pulse(16'h0020);
    waitIrq(8'h15, 4'h4, 1'b1);
    wr(cA(3'h7, CH_SRC_W), 32'h300);
    wr(cA(3'h7, CH_DST_W), 32'h400);
    wr(cA(3'h7, CH_CTL_W), 32'h500);
    wr(nA(4'h6), nc(4'h4, 1'b1, 1'b0, 1'b1, 3'h7));
    pulse(16'h0040);
    waitXfer(24'h300, 24'h400, 1'b0);
    pulse(16'h0040);
    waitXfer(24'h301, 24'h400, 1'b0);
    rd(cA(3'h7, CH_CTL_W), 32'h500);
    wr(EDGE_OFS, 32'h2);
    wr(nA(4'h0), nc(4'h1, 1'b1, 1'b0, 1'b0, 3'h0));
    extPin <= 4'h1;
    quiet();
    extPin <= 4'h0;
    waitIrq(8'h10, 4'h1, 1'b1);
    wr(EDGE_OFS, 32'h1);
    extPin <= 4'h1;
    waitIrq(8'h10, 4'h1, 1'b1);
    trapNum <= 8'h25;
    trapReq <= 1'b1;
    @(posedge core_clk);
    trapReq <= 1'b0;
    waitIrq(8'h25, 4'h0, 1'b1);
    close_out();
  end
endmodule : test_interrupt_and_event_transfer_unit
